// [src/mls_pkg.sv]
// Shared constants, types and encodings of the multi-event latching scaler
package mls_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH     = 160;
  localparam int CNT_W      = 64;
  localparam int WORD_W     = 32;
  localparam int FIFO_AW    = 12;
  localparam int FIFO_DEPTH = 4096;
  localparam int MASK_WORDS = NUM_CH / WORD_W;

  localparam logic [7:0]         CH_LAST       = 8'(NUM_CH - 1);
  localparam logic [2:0]         MASK_LAST     = 3'(MASK_WORDS - 1);
  localparam logic [FIFO_AW:0]   FIFO_FULL_CNT = 13'(FIFO_DEPTH);
  localparam logic [FIFO_AW:0]   MASK_SIZE     = 13'(MASK_WORDS);

  // ==========================================================
  // Timing: one microsecond tick derived from the system clock
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 1000;
  localparam int US_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);

  // ==========================================================
  // Event header markers (bits 31:28 of the first word)
  localparam logic [3:0] HDR_MARK    = 4'ha;
  localparam logic [3:0] LEGACY_MARK = 4'h5;

  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    TRIG_EXT   = 2'h0,
    TRIG_DWELL = 2'h1,
    TRIG_SW    = 2'h2
  } trig_sel_e;

  typedef enum logic [1:0] {
    GATE_OFF     = 2'h0,
    GATE_INHIBIT = 2'h1,
    GATE_TEST    = 2'h2,
    GATE_RESET   = 2'h3
  } gate_mode_e;

  typedef enum logic [1:0] {
    TAG_NONE = 2'h0,
    TAG_32   = 2'h1,
    TAG_64   = 2'h2
  } tag_mode_e;

  // Gray coded along idle, header, mask, tag, data
  typedef enum logic [2:0] {
    W_IDLE = 3'h0,
    W_HDR  = 3'h1,
    W_MASK = 3'h3,
    W_TAG  = 3'h2,
    W_DATA = 3'h6
  } wr_state_e;

endpackage

// [src/chan_if.sv]
// Control and value bundle between the scaler core and one channel counter
`timescale 1ns/100ps
interface chan_if;
  logic        latch;
  logic        clear;
  logic        inhibit;
  logic        test;
  logic        depth64;
  logic [31:0] live;
  logic [63:0] held;

  modport cnt (input latch, clear, inhibit, test, depth64, output live, held);
  modport ctl (output latch, clear, inhibit, test, depth64, input live, held);
endinterface

// [src/chan_counter.sv]
// One scaler channel: leading edge counter with snapshot latch
`timescale 1ns/100ps
module chan_counter
  import mls_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic pulse_in,
  chan_if.cnt      bus
);

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] held;
  } chan_s;

  chan_s s_r;
  chan_s s_nxt;
  logic  inc;

  // ==========================================================
  // Counting and latching
  // Inputs are sampled once per clock, so pulses must last at least one clock period
  always_comb begin
    s_nxt      = s_r;
    s_nxt.prev = pulse_in;
    inc = !bus.inhibit && ((pulse_in && !s_r.prev) || bus.test); // RULE3 RULE4 RULE15
    if (bus.latch) begin
      s_nxt.held = s_r.cnt; // RULE5 RULE6
    end
    if (bus.clear) begin
      s_nxt.cnt = inc ? CNT_W'(1) : '0; // RULE16 RULE17
    end else if (inc) begin
      s_nxt.cnt = s_r.cnt + CNT_W'(1); // RULE3
    end
    if (!bus.depth64) begin
      s_nxt.cnt[CNT_W-1:WORD_W] = '0; // RULE2
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.live = s_r.cnt[WORD_W-1:0];
  assign bus.held = s_r.held;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_LATCH_SNAP: assert property (bus.latch |=> s_r.held == $past(s_r.cnt)) // RULE5
    else $error("latch did not capture the live count");
  AST_COUNT_STEP: assert property (bus.depth64 && !bus.clear && !bus.inhibit
      && pulse_in && !s_r.prev |=> s_r.cnt == $past(s_r.cnt) + CNT_W'(1)) // RULE3
    else $error("leading edge not counted once");
  AST_DEPTH32: assert property (!bus.depth64 |=> s_r.cnt[CNT_W-1:WORD_W] == '0) // RULE2
    else $error("32 bit depth leaks into upper half");
  AST_INHIBIT: assert property (bus.inhibit && !bus.clear |=> s_r.cnt == $past(s_r.cnt)) // RULE15
    else $error("count moved while inhibited");

endmodule

// [src/latching_scaler.sv]
// Multi-event latching scaler core: counters, triggers and event buffer
// What this block does
// (RULE1) Up to 160 independent input counting channels
// (RULE2) Counter depth selectable as 32 or 64
// (RULE3) Count one per leading input edge
// (RULE4) Count fast inputs without missing edges; here inputs are sampled once per clock, shorter pulses can be missed
// (RULE5) Trigger latches all counters together, counting continues
// (RULE6) Captured and read values are always consistent
// (RULE7) Event is header, optional masks, latched values
// (RULE8) Event buffer holds 4096 words of 32
// (RULE9) New trigger accepted while unread events remain
// (RULE10) Master reads events out, back-to-back words
// (RULE11) Trigger from external, dwell timer, or software
// (RULE12) Dwell period 1 us to 4000 s
// (RULE13) Optional 32 or 64 bit time tag
// (RULE14) Live low 32 bits readable any time
// (RULE15) Gate input inhibits, tests or resets counters
// (RULE16) Auto-reset clears counters after each trigger latch
// (RULE17) Counter-reset command clears all counters
// (RULE18) Legacy event payload format selectable
// (RULE19) Trigger without room for event is dropped
// (RULE20) Time tag counts clocks, cleared by resets; here only rst_in and counter-reset clear it
`timescale 1ns/100ps
module latching_scaler
  import mls_pkg::*;
(
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  input  wire logic [159:0]          chan_in,
  input  wire logic                  external_trigger_input_in,
  input  wire logic                  auxiliary_gate_input_in,
  input  wire mls_pkg::trig_sel_e    trig_sel_in,
  input  wire logic [31:0]           dwell_us_in,
  input  wire logic                  sw_trig_in,
  input  wire logic                  cnt_reset_in,
  input  wire logic                  auto_reset_in,
  input  wire mls_pkg::gate_mode_e   gate_mode_in,
  input  wire logic                  depth64_in,
  input  wire mls_pkg::tag_mode_e    tag_mode_in,
  input  wire logic                  mask_word_en_in,
  input  wire logic                  legacy_in,
  input  wire logic [159:0]          chan_enable_in,
  input  wire logic [7:0]            live_sel_in,
  output logic [31:0]                live_data_out,
  input  wire logic                  fifo_rd_in,
  output logic [31:0]                fifo_data_out,
  output logic                       fifo_valid_out,
  output logic                       fifo_empty_out,
  output logic [12:0]                fifo_words_out,
  output logic                       busy_out,
  output logic                       trig_lost_out
);

  typedef struct packed {
    wr_state_e          st;
    logic               ext_q;
    logic               aux_q;
    logic [4:0]         us_cnt;
    logic [31:0]        dwell_cnt;
    logic [63:0]        tag;
    logic [63:0]        tag_snap;
    logic [NUM_CH-1:0]  en_snap;
    logic               mask_on;
    logic [1:0]         tag_w;
    logic               d64;
    logic               legacy;
    logic [2:0]         sub;
    logic [7:0]         idx;
    logic               half;
    logic [15:0]        ev_num;
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic [FIFO_AW:0]   count;
    logic [31:0]        rd_data;
    logic               rd_valid;
    logic               empty;
    logic [31:0]        live;
    logic               lost;
    logic               busy;
  } core_s;

  core_s              s_r;
  core_s              s_nxt;
  logic [WORD_W-1:0]  mem [FIFO_DEPTH];
  logic [WORD_W-1:0]  live_arr [NUM_CH];
  logic [CNT_W-1:0]   held_arr [NUM_CH];
  logic               latch_all;
  logic               clear_all;
  logic               inhibit_all;
  logic               test_all;
  logic               tick;
  logic               dwell_fire;
  logic               trig_req;
  logic               accept;
  logic               fwe;
  logic               frd;
  logic [WORD_W-1:0]  fwd;
  logic               eff_mask;
  logic               eff_d64;
  logic [1:0]         eff_tagw;
  logic [7:0]         nact;
  logic [FIFO_AW:0]   ev_size;
  logic [FIFO_AW:0]   free_words;
  logic [7:0]         snap_nact;

  // Number of enabled channels in a mask
  function automatic logic [7:0] count_ones(input logic [NUM_CH-1:0] m);
    logic [7:0] c;
    c = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      c = c + 8'(m[i]);
    end
    return c;
  endfunction

  // ==========================================================
  // Channel array
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    chan_if cif ();
    assign cif.latch   = latch_all;
    assign cif.clear   = clear_all;
    assign cif.inhibit = inhibit_all;
    assign cif.test    = test_all;
    assign cif.depth64 = depth64_in;
    assign live_arr[g] = cif.live;
    assign held_arr[g] = cif.held;
    chan_counter u_chan ( // RULE1
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .pulse_in (chan_in[g]),
      .bus      (cif.cnt)
    );
  end

  // ==========================================================
  // Next state of the core
  always_comb begin
    s_nxt          = s_r;
    fwe            = 1'b0;
    fwd            = '0;
    s_nxt.ext_q    = external_trigger_input_in;
    s_nxt.aux_q    = auxiliary_gate_input_in;
    s_nxt.lost     = 1'b0;
    s_nxt.rd_valid = 1'b0;

    // Free running time tag
    s_nxt.tag = cnt_reset_in ? '0 : s_r.tag + 64'h1; // RULE20

    // Microsecond tick and dwell period; a period of 0 behaves as 1 us
    tick         = (s_r.us_cnt == US_LAST);
    s_nxt.us_cnt = tick ? '0 : s_r.us_cnt + 5'h1;
    dwell_fire   = 1'b0;
    if (trig_sel_in != TRIG_DWELL) begin
      s_nxt.dwell_cnt = '0;
    end else if (tick) begin
      if (dwell_us_in <= 32'h1 || s_r.dwell_cnt >= dwell_us_in - 32'h1) begin
        dwell_fire      = 1'b1; // RULE12
        s_nxt.dwell_cnt = '0;
      end else begin
        s_nxt.dwell_cnt = s_r.dwell_cnt + 32'h1;
      end
    end

    // Trigger source
    case (trig_sel_in) // RULE11
      TRIG_EXT:   trig_req = external_trigger_input_in && !s_r.ext_q;
      TRIG_DWELL: trig_req = dwell_fire;
      TRIG_SW:    trig_req = sw_trig_in;
      default:    trig_req = 1'b0;
    endcase

    // Size of the next event under the present settings
    eff_mask   = mask_word_en_in && !legacy_in; // RULE18
    eff_d64    = depth64_in && !legacy_in;
    eff_tagw   = legacy_in ? 2'h0 : (tag_mode_in == TAG_64) ? 2'h2 :
                 (tag_mode_in == TAG_32) ? 2'h1 : 2'h0; // RULE13
    nact       = count_ones(chan_enable_in);
    ev_size    = 13'h1 + (eff_mask ? MASK_SIZE : '0) + 13'(eff_tagw)
                 + (eff_d64 ? {4'h0, nact, 1'b0} : {5'h0, nact});
    free_words = FIFO_FULL_CNT - s_r.count;
    // Only whole events go in, so the reader never sees a torn event
    accept     = trig_req && s_r.st == W_IDLE && free_words >= ev_size; // RULE9 RULE19
    s_nxt.lost = trig_req && !accept; // RULE19

    // Gate input function and counter controls
    latch_all   = accept; // RULE5
    inhibit_all = gate_mode_in == GATE_INHIBIT && auxiliary_gate_input_in; // RULE15
    test_all    = gate_mode_in == GATE_TEST && auxiliary_gate_input_in
                  && !s_r.aux_q; // RULE15
    clear_all   = (accept && auto_reset_in) || cnt_reset_in // RULE16 RULE17
                  || (gate_mode_in == GATE_RESET && auxiliary_gate_input_in); // RULE15

    // Event writer
    snap_nact = count_ones(s_r.en_snap);
    case (s_r.st)
      W_IDLE: begin
        if (accept) begin
          s_nxt.st       = W_HDR;
          s_nxt.tag_snap = s_r.tag;
          s_nxt.en_snap  = chan_enable_in;
          s_nxt.mask_on  = eff_mask;
          s_nxt.tag_w    = eff_tagw;
          s_nxt.d64      = eff_d64;
          s_nxt.legacy   = legacy_in;
          s_nxt.sub      = '0;
          s_nxt.idx      = '0;
          s_nxt.half     = 1'b0;
        end
      end
      W_HDR: begin
        fwe = 1'b1; // RULE7
        fwd = s_r.legacy ? {LEGACY_MARK, 4'h0, snap_nact, s_r.ev_num} // RULE18
              : {HDR_MARK, s_r.tag_w, s_r.d64, s_r.mask_on, snap_nact, s_r.ev_num};
        s_nxt.st = s_r.mask_on ? W_MASK : (s_r.tag_w != 2'h0) ? W_TAG : W_DATA;
      end
      W_MASK: begin
        fwe = 1'b1; // RULE7
        fwd = s_r.en_snap[{s_r.sub, 5'h0} +: WORD_W];
        if (s_r.sub == MASK_LAST) begin
          s_nxt.sub = '0;
          s_nxt.st  = (s_r.tag_w != 2'h0) ? W_TAG : W_DATA;
        end else begin
          s_nxt.sub = s_r.sub + 3'h1;
        end
      end
      W_TAG: begin
        fwe = 1'b1; // RULE13
        fwd = s_r.sub[0] ? s_r.tag_snap[63:32] : s_r.tag_snap[31:0];
        if ({1'b0, s_r.sub[0]} + 2'h1 == s_r.tag_w) begin
          s_nxt.st = W_DATA;
        end
        s_nxt.sub = s_r.sub + 3'h1;
      end
      W_DATA: begin
        // Disabled channels are skipped, one cycle each
        if (s_r.en_snap[s_r.idx]) begin
          fwe = 1'b1; // RULE7
          fwd = s_r.half ? held_arr[s_r.idx][63:32] : held_arr[s_r.idx][31:0];
        end
        if (s_r.en_snap[s_r.idx] && s_r.d64 && !s_r.half) begin
          s_nxt.half = 1'b1;
        end else begin
          s_nxt.half = 1'b0;
          if (s_r.idx == CH_LAST) begin
            s_nxt.st     = W_IDLE;
            s_nxt.ev_num = s_r.ev_num + 16'h1;
          end else begin
            s_nxt.idx = s_r.idx + 8'h1;
          end
        end
      end
      default: s_nxt.st = W_IDLE;
    endcase

    // Buffer pointers; space was reserved at the trigger so writes never overflow
    frd = fifo_rd_in && s_r.count != '0; // RULE10
    if (fwe) begin
      s_nxt.wr_ptr = s_r.wr_ptr + 12'h1;
    end
    if (frd) begin
      s_nxt.rd_data  = mem[s_r.rd_ptr];
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_ptr   = s_r.rd_ptr + 12'h1;
    end
    s_nxt.count = s_r.count + 13'(fwe) - 13'(frd); // RULE8
    s_nxt.empty = s_nxt.count == '0;
    s_nxt.busy  = s_nxt.st != W_IDLE;

    // Live read is a plain copy; counters move synchronously so no tearing
    s_nxt.live = (live_sel_in < 8'(NUM_CH)) ? live_arr[live_sel_in] : '0; // RULE14 RULE6
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      s_r       <= '0;
      s_r.empty <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Event memory has no reset; only written words are ever read back
  always_ff @(posedge clock_in) begin
    if (fwe) begin
      mem[s_r.wr_ptr] <= fwd; // RULE8
    end
  end

  // ==========================================================
  // Outputs, all straight from the state register
  assign live_data_out  = s_r.live;
  assign fifo_data_out  = s_r.rd_data;
  assign fifo_valid_out = s_r.rd_valid;
  assign fifo_empty_out = s_r.empty;
  assign fifo_words_out = s_r.count;
  assign busy_out       = s_r.busy;
  assign trig_lost_out  = s_r.lost;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_DROP_NO_ROOM: assert property (trig_req && !accept |=> trig_lost_out
      && ($past(busy_out) || !busy_out)) // RULE19
    else $error("refused trigger not flagged");
  AST_TAG_STEP: assert property (!cnt_reset_in |=> s_r.tag == $past(s_r.tag) + 64'h1) // RULE20
    else $error("time tag did not advance");
  AST_TAG_CLEAR: assert property (cnt_reset_in |=> s_r.tag == '0) // RULE20
    else $error("time tag not cleared by counter reset");
  AST_FIFO_BOUND: assert property (s_r.count <= FIFO_FULL_CNT) // RULE8
    else $error("event buffer count beyond depth");
  AST_EVENT_START: assert property (accept |=> s_r.st == W_HDR ##1 $past(fwe)) // RULE7
    else $error("accepted trigger did not write a header");
  AST_READ_ANSWER: assert property (fifo_rd_in && !fifo_empty_out
      |=> fifo_valid_out && fifo_words_out <= $past(fifo_words_out)) // RULE10
    else $error("read of a non-empty buffer gave no word");
  AST_AUTO_RESET: assert property (accept && auto_reset_in |-> clear_all && latch_all) // RULE16
    else $error("auto reset not paired with latch");
  AST_BUSY_REFUSE: assert property (busy_out && trig_req |=> trig_lost_out) // RULE9
    else $error("trigger during event write not refused");

  COV_EVENT: cover property (accept ##[1:400] !busy_out);
  COV_DROP: cover property (trig_lost_out && !busy_out);
  COV_LEGACY: cover property (accept && legacy_in);
  COV_BACK_TO_BACK_READ: cover property (fifo_valid_out [*4]);

endmodule

// [tb/event_reader.sv]
// Bus master model that pulls event words out of the scaler buffer
`timescale 1ns/100ps
module event_reader (
  input  wire logic        clock_in,
  input  wire logic        run_in,
  input  wire logic        slow_in,
  input  wire logic        fifo_empty_in,
  input  wire logic        fifo_valid_in,
  input  wire logic [31:0] fifo_data_in,
  output logic             fifo_rd_out
);
  // ==========================================================
  // Read strobe and captured words
  logic [31:0] got[$];
  logic        phase_r = 1'b0;

  // Slow mode strobes every other cycle to stall the block transfer
  always @(negedge clock_in) begin
    phase_r <= ~phase_r;
    fifo_rd_out <= run_in && !fifo_empty_in && (!slow_in || phase_r);
  end

  // Keep every delivered word in arrival order; taken mid-cycle where valid and data have settled
  always @(negedge clock_in) begin
    if (fifo_valid_in === 1'b1) begin
      got.push_back(fifo_data_in);
    end
  end
endmodule

// [tb/multievent_latching_scaler_tb.sv]
// Self-checking bench of the multi-event latching scaler
`timescale 1ns/100ps
module multievent_latching_scaler_tb;
  import mls_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (a), (b)); end end
  // ==========================================================
  // Stimulus and observed signals
  logic         clock_in = 1'b0;
  logic         rst_in = 1'b1;
  logic [159:0] chan_in = '0;
  logic         ext_trig = 1'b0;
  logic         gate = 1'b0;
  trig_sel_e    trig_sel = TRIG_SW;
  logic [31:0]  dwell_us = 32'h1;
  logic         sw_trig = 1'b0;
  logic         cnt_reset = 1'b0;
  logic         auto_reset = 1'b0;
  gate_mode_e   gate_mode = GATE_OFF;
  logic         depth64 = 1'b0;
  tag_mode_e    tag_mode = TAG_NONE;
  logic         mask_en = 1'b0;
  logic         legacy = 1'b0;
  logic [159:0] chan_en = '0;
  logic [7:0]   live_sel = 8'h0;
  logic         rd_run = 1'b0;
  logic         rd_slow = 1'b0;
  logic [31:0]  live_data;
  logic [31:0]  fifo_data;
  logic         fifo_rd;
  logic         fifo_valid;
  logic         fifo_empty;
  logic [12:0]  fifo_words;
  logic         busy;
  logic         trig_lost;
  logic [31:0]  tag_w[2];
  int           tcyc[2];
  int           num_errors = 0;
  int           total_checks = 0;
  int           cyc = 0;
  int           evn = 0;
  int           t0;

  always #20 clock_in = ~clock_in;

  latching_scaler i_dut (.clock_in(clock_in), .rst_in(rst_in), .chan_in(chan_in),
    .external_trigger_input_in(ext_trig), .auxiliary_gate_input_in(gate),
    .trig_sel_in(trig_sel), .dwell_us_in(dwell_us), .sw_trig_in(sw_trig),
    .cnt_reset_in(cnt_reset), .auto_reset_in(auto_reset), .gate_mode_in(gate_mode),
    .depth64_in(depth64), .tag_mode_in(tag_mode), .mask_word_en_in(mask_en),
    .legacy_in(legacy), .chan_enable_in(chan_en), .live_sel_in(live_sel),
    .live_data_out(live_data), .fifo_rd_in(fifo_rd), .fifo_data_out(fifo_data),
    .fifo_valid_out(fifo_valid), .fifo_empty_out(fifo_empty),
    .fifo_words_out(fifo_words), .busy_out(busy), .trig_lost_out(trig_lost));

  event_reader i_reader (.clock_in(clock_in), .run_in(rd_run), .slow_in(rd_slow),
    .fifo_empty_in(fifo_empty), .fifo_valid_in(fifo_valid), .fifo_data_in(fifo_data),
    .fifo_rd_out(fifo_rd));

  // Cycle count doubles as a hang guard; the full-buffer test dominates the run
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // Helpers
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // One high and one low cycle per count, the fastest legal pulse train
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      chan_in[ch] = 1'b1;
      step(1);
      chan_in[ch] = 1'b0;
      step(1);
    end
  endtask

  task automatic live(input logic [7:0] ch, input logic [31:0] exp);
    live_sel = ch;
    step(3);
    `CHK(live_data, exp)
  endtask

  task automatic trig();
    sw_trig = 1'b1;
    step(1);
    sw_trig = 1'b0;
    `CHK(busy, 1'b1)
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) step(1);
    `CHK(busy, 1'b0)
  endtask

  task automatic drain(input int n);
    i_reader.got.delete();
    rd_run = 1'b1;
    for (int i = 0; i < 9000 && i_reader.got.size() < n; i++) step(1);
    step(3);
    rd_run = 1'b0;
    `CHK(i_reader.got.size(), n)
    `CHK(fifo_empty, 1'b1)
  endtask

  function automatic logic [31:0] hdr(input logic [1:0] tw, input logic w, input logic m,
                                      input logic [7:0] n);
    return {HDR_MARK, tw, w, m, n, evn[15:0]};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_count();
    `CHK(fifo_empty, 1'b1)
    `CHK(fifo_words, 13'h0)
    pulse(7, 3);
    pulse(159, 1);
    live(8'h07, 32'h3);
    live(8'h9f, 32'h1);
    live(8'ha0, 32'h0);
    $display("test count done");
  endtask

  // Edge right after the latch and a trigger while busy must stay out
  task automatic t_basic();
    chan_en[7] = 1'b1;
    chan_en[159] = 1'b1;
    trig();
    chan_in[7] = 1'b1;
    step(2);
    sw_trig = 1'b1;
    step(1);
    sw_trig = 1'b0;
    `CHK(trig_lost, 1'b1)
    chan_in[7] = 1'b0;
    wait_idle();
    `CHK(fifo_words, 13'h3)
    rd_slow = 1'b1;
    drain(3);
    rd_slow = 1'b0;
    `CHK(i_reader.got[0], hdr(2'h0, 1'b0, 1'b0, 8'h2))
    `CHK(i_reader.got[1], 32'h3)
    `CHK(i_reader.got[2], 32'h1)
    evn++;
    live(8'h07, 32'h4);
    $display("test basic event done");
  endtask

  task automatic t_wide();
    depth64 = 1'b1;
    tag_mode = TAG_32;
    mask_en = 1'b1;
    chan_en = '0;
    chan_en[7] = 1'b1;
    for (int k = 0; k < 2; k++) begin
      tag_mode = (k == 0) ? TAG_32 : TAG_64;
      tcyc[k] = cyc;
      trig();
      wait_idle();
      `CHK(fifo_words, 13'(9 + k))
      drain(9 + k);
      `CHK(i_reader.got[0], hdr(2'(k + 1), 1'b1, 1'b1, 8'h1))
      `CHK(i_reader.got[1], 32'h80)
      `CHK(i_reader.got[5], 32'h0)
      `CHK(i_reader.got[7], (k == 0) ? 32'h4 : 32'h0)
      `CHK(i_reader.got[7 + k], 32'h4)
      `CHK(i_reader.got[8 + k], 32'h0)
      tag_w[k] = i_reader.got[6];
      evn++;
    end
    `CHK(tag_w[1] - tag_w[0], 32'(tcyc[1] - tcyc[0]))
    depth64 = 1'b0;
    tag_mode = TAG_NONE;
    mask_en = 1'b0;
    $display("test wide event done");
  endtask

  task automatic t_clear();
    auto_reset = 1'b1;
    trig();
    wait_idle();
    auto_reset = 1'b0;
    live(8'h07, 32'h0);
    drain(2);
    `CHK(i_reader.got[1], 32'h4)
    evn++;
    pulse(7, 2);
    cnt_reset = 1'b1;
    step(1);
    cnt_reset = 1'b0;
    live(8'h07, 32'h0);
    $display("test clear done");
  endtask

  task automatic t_gate();
    gate_mode = GATE_INHIBIT;
    gate = 1'b1;
    pulse(7, 2);
    live(8'h07, 32'h0);
    gate = 1'b0;
    gate_mode = GATE_TEST;
    step(1);
    gate = 1'b1;
    step(2);
    live(8'h07, 32'h1);
    live(8'h64, 32'h1);
    gate_mode = GATE_RESET;
    live(8'h07, 32'h0);
    gate = 1'b0;
    gate_mode = GATE_OFF;
    $display("test gate done");
  endtask

  // Legacy must ignore the wide, mask and tag settings
  task automatic t_legacy();
    legacy = 1'b1;
    depth64 = 1'b1;
    mask_en = 1'b1;
    tag_mode = TAG_64;
    chan_en[100] = 1'b1;
    pulse(7, 1);
    trig();
    wait_idle();
    drain(3);
    `CHK(i_reader.got[0], {LEGACY_MARK, 4'h0, 8'h2, evn[15:0]})
    `CHK(i_reader.got[1], 32'h1)
    evn++;
    legacy = 1'b0;
    depth64 = 1'b0;
    mask_en = 1'b0;
    tag_mode = TAG_NONE;
    $display("test legacy done");
  endtask

  task automatic t_sources();
    trig_sel = TRIG_EXT;
    ext_trig = 1'b1;
    for (int i = 0; i < 5 && busy !== 1'b1; i++) step(1);
    `CHK(busy, 1'b1)
    ext_trig = 1'b0;
    wait_idle();
    dwell_us = 32'ha;
    trig_sel = TRIG_DWELL;
    for (int i = 0; i < 600 && busy !== 1'b1; i++) step(1);
    t0 = cyc;
    wait_idle();
    for (int i = 0; i < 600 && busy !== 1'b1; i++) step(1);
    `CHK(cyc - t0, 250)
    trig_sel = trig_sel_e'(2'h3);
    wait_idle();
    rd_run = 1'b1;
    step(40);
    rd_run = 1'b0;
    `CHK(fifo_empty, 1'b1)
    $display("test sources done");
  endtask

  // 25 full events fit, the 26th finds 71 free words and is refused
  task automatic t_full();
    trig_sel = TRIG_SW;
    chan_en = '1;
    for (int i = 0; i < 26; i++) begin
      sw_trig = 1'b1;
      step(1);
      sw_trig = 1'b0;
      `CHK(trig_lost, 1'(i == 25))
      wait_idle();
    end
    `CHK(fifo_words, 13'(25 * 161))
    drain(25 * 161);
    $display("test full buffer done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    step(4);
    rst_in = 1'b0;
    step(1);
    t_count();
    t_basic();
    t_wide();
    t_clear();
    t_gate();
    t_legacy();
    t_sources();
    t_full();
    wrap_up();
  end
endmodule
